// ### hw/flw_pkg.sv
// Purpose: Shared constants and types of the flow sensor command port
// Assumes: 125 MHz core clock
// Notes:   Timing figures are kept in their own unit and converted here
`default_nettype none
package flw_pkg;
   // Target addressing and command codes
   localparam logic [6:0]  DEV_ADDR  = 7'h08;
   localparam logic [6:0]  GC_ADDR   = 7'h00;
   localparam logic [7:0]  GC_RESET  = 8'h06;
   localparam logic [15:0] CMD_WATER = 16'h3608;
   localparam logic [15:0] CMD_IPA   = 16'h3615;
   localparam logic [15:0] CMD_STOP  = 16'h3ff9;
   // Checksum
   localparam logic [7:0]  CRC_POLY  = 8'h31;
   localparam logic [7:0]  CRC_INIT  = 8'hff;
   // Serial framing
   localparam logic [3:0]  BITS      = 4'h8;
   localparam logic [1:0]  PART_HI   = 2'h0;
   localparam logic [1:0]  PART_LO   = 2'h1;
   localparam logic [1:0]  PART_CRC  = 2'h2;
   localparam logic [1:0]  WORD_FLAG = 2'h2;
   localparam logic [1:0]  WORD_END  = 2'h3;
   localparam logic [7:0]  IDLE_BYTE = 8'hff;
   // Flag word bit positions
   localparam int          FLAG_AIR  = 0;
   localparam int          FLAG_HIGH = 1;
   localparam int          FLAG_SMTH = 5;
   // Register byte offsets
   localparam logic [3:0]  OFS_CTRL  = 4'h0;
   localparam logic [3:0]  OFS_SMPL  = 4'h4;
   localparam logic [3:0]  OFS_EVNT  = 4'h8;
   localparam logic [3:0]  OFS_CMD   = 4'hc;
   // Control and status bit positions
   localparam int          CS_MEAS   = 0;
   localparam int          CS_VALID  = 1;
   localparam int          CS_IPA    = 2;
   localparam int          CS_BUSY   = 3;
   localparam int          CS_SMTH   = 4;
   localparam int          EV_AIR    = 0;
   localparam int          EV_HIGH   = 1;
   // Timing
   localparam int unsigned CLK_MHZ   = 125;
   localparam int unsigned T_WARM_US = 12000;
   localparam int unsigned T_STOP_US = 500;
   localparam int unsigned T_RST_US  = 25000;
   localparam int unsigned WARM_CYC  = T_WARM_US * CLK_MHZ;
   localparam int unsigned STOP_CYC  = T_STOP_US * CLK_MHZ;
   localparam int unsigned RST_CYC   = T_RST_US * CLK_MHZ;
   localparam int          TMR_W     = 22;
   // Serial engine states
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_RX   = 7'h04,
      ST_ACK  = 7'h08,
      ST_TX   = 7'h10,
      ST_MACK = 7'h20,
      ST_IGN  = 7'h40
   } flw_state_t;
endpackage : flw_pkg
`default_nettype wire

// ### hw/flw_crc_if.sv
// Purpose: Carries one data word to the checksum unit and its checksum back
// Assumes: Purely combinational path
// Notes:   calc side computes, user side supplies the word
`default_nettype none
interface flw_crc_if;
   logic [15:0] data;
   logic [7:0]  crc;
   modport calc (input data, output crc);
   modport user (output data, input crc);
endinterface : flw_crc_if
`default_nettype wire

// ### hw/flw_crc8.sv
// Purpose: Checksum of one 16-bit word, most significant bit first
// Assumes: Word is stable for the cycle it is read
// Notes:   No reflection and no final inversion
`default_nettype none
module flw_crc8
   import flw_pkg::*;
(
   // Word in, checksum out
   flw_crc_if.calc cif
);
   logic [7:0] c;
   logic       fb;

   always_comb begin
      c  = CRC_INIT;
      fb = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         fb = c[7] ^ cif.data[i];
         c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
      cif.crc = c;
   end
endmodule : flw_crc8
`default_nettype wire

// ### hw/flw_sensor_port.sv
// Purpose: Two-wire target and command decoder of a liquid flow sensor
// Assumes: SCL and SDA come from the pins; samples are written by software
// Notes:   Pins are oversampled; no clock stretching is done
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`default_nettype none
// Behaviour
// - Answer only at address 8 and general call
// - Header is address then direction bit
// - Command is 16 bits, high byte first
// - Each read word followed by its checksum
// - Master NACK plus STOP ends read cleanly
// - 0x3608 water start, 0x3615 alcohol start
// - First results readable 12 ms after start
// - NACK read header while no results exist
// - Read gives flow, temperature, flags with checksums
// - Each read header delivers the latest results
// - Flag bit 0 air, bit 1 high flow
// - Flag bit 5 shows exponential smoothing
// - Flag bits 2-4 and 6-15 reserved
// - 0x3ff9 stops measurement and enters idle
// - Up to 0.5 ms deaf after stop
// - While measuring accept only stop or reset
// - General call 0x06 resets, deaf 25 ms
// - Checksum poly 0x31, init 0xff, no reflection
// - Air and high flow flags latch until read
// - Flow and temperature are signed 16-bit
module flw_sensor_port
   import flw_pkg::*;
#(
   parameter int unsigned WARM_CYCLES  = WARM_CYC,
   parameter int unsigned STOP_CYCLES  = STOP_CYC,
   parameter int unsigned RESET_CYCLES = RST_CYC
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // Two-wire bus pins
   input  wire logic        SCL_I,
   input  wire logic        SDA_I,
   output var  logic        SDA_O,
   output var  logic        SDA_OE_N,
   // Register bus
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output var  logic [31:0] AVS_READDATA,
   output var  logic        AVS_WAITREQUEST
);
   typedef struct packed {
      logic [2:0]       scl_sy;
      logic [2:0]       sda_sy;
      flw_state_t       st;
      logic [3:0]       bitcnt;
      logic [7:0]       sr;
      logic             rd;
      logic             gc;
      logic             second;
      logic             ackd;
      logic [7:0]       cmd_hi;
      logic [1:0]       part;
      logic [1:0]       widx;
      logic [2:0][15:0] snap;
      logic             sda_o;
      logic             sda_oe_n;
      logic             meas;
      logic             ipa;
      logic             valid;
      logic             busy;
      logic [TMR_W-1:0] tmr;
      logic [15:0]      flow;
      logic [15:0]      temp;
      logic             air;
      logic             high;
      logic             smooth;
      logic [15:0]      last_cmd;
      logic             waitrequest;
      logic [31:0]      rdata;
   } flw_regs_t;

   flw_regs_t   s;
   flw_regs_t   n;
   flw_crc_if   cif ();

   logic        scl_rise;
   logic        scl_fall;
   logic        sda_in;
   logic        start_c;
   logic        stop_c;
   logic        wr_take;
   logic        clr;
   logic        ev_air;
   logic        ev_high;
   logic        ack;
   logic [15:0] cmd;
   logic [15:0] flags_word;
   logic [15:0] cur_word;
   logic [7:0]  cur_byte;
   logic [31:0] smp;
   logic [31:0] rd_mux;
   logic [1:0]  nx_part;
   logic [1:0]  nx_widx;

   // Edges are taken only from the second and third stage, never the first
   assign scl_rise = s.scl_sy[1] & ~s.scl_sy[2];
   assign scl_fall = ~s.scl_sy[1] & s.scl_sy[2];
   assign sda_in   = s.sda_sy[1];
   assign start_c  = s.scl_sy[1] & s.scl_sy[2] & ~s.sda_sy[1] & s.sda_sy[2];
   assign stop_c   = s.scl_sy[1] & s.scl_sy[2] & s.sda_sy[1] & ~s.sda_sy[2];

   // Reserved bits forced low so the master may ignore them
   assign flags_word = {10'h000, s.smooth, 3'h0, s.high, s.air};

   assign cur_word = (s.widx == WORD_END) ? 16'h0000 : s.snap[s.widx];
   assign cif.data = cur_word;

   flw_crc8 u_crc (
      .cif (cif)
   );

   always_comb begin
      unique case (s.part)
         PART_HI:  cur_byte = cur_word[15:8];
         PART_LO:  cur_byte = cur_word[7:0];
         default:  cur_byte = cif.crc;
      endcase
      // Past the ninth byte the line is left released
      if (s.widx == WORD_END) begin
         cur_byte = IDLE_BYTE;
      end
   end

   always_comb begin
      unique case (AVS_ADDRESS)
         OFS_CTRL: rd_mux = {27'h0, s.smooth, s.busy, s.ipa, s.valid, s.meas};
         OFS_SMPL: rd_mux = {s.temp, s.flow};
         OFS_EVNT: rd_mux = {16'h0000, flags_word};
         OFS_CMD:  rd_mux = {16'h0000, s.last_cmd};
         default:  rd_mux = 32'h0000_0000;
      endcase
   end

   always_comb begin
      n        = s;
      ack      = 1'b0;
      cmd      = {s.cmd_hi, s.sr};
      smp      = {s.temp, s.flow};
      nx_part  = s.part;
      nx_widx  = s.widx;
      n.scl_sy = {s.scl_sy[1:0], SCL_I};
      n.sda_sy = {s.sda_sy[1:0], SDA_I};

      // Bus slave: answer one cycle after the request, complete on the next edge
      wr_take       = AVS_WRITE & ~s.waitrequest;
      n.waitrequest = 1'b1;
      if ((AVS_READ | AVS_WRITE) & s.waitrequest) begin
         n.waitrequest = 1'b0;
         n.rdata       = rd_mux;
      end
      for (int b = 0; b < 4; b++) begin
         if (AVS_BYTEENABLE[b]) begin
            smp[b*8 +: 8] = AVS_WRITEDATA[b*8 +: 8];
         end
      end
      if (wr_take && AVS_ADDRESS == OFS_SMPL && s.meas) begin
         n.temp = smp[31:16];
         n.flow = smp[15:0];
      end
      if (wr_take && AVS_ADDRESS == OFS_CTRL && AVS_BYTEENABLE[0]) begin
         n.smooth = AVS_WRITEDATA[CS_SMTH] & s.meas;
      end
      ev_air  = wr_take && AVS_ADDRESS == OFS_EVNT && AVS_BYTEENABLE[0] && AVS_WRITEDATA[EV_AIR] && s.meas;
      ev_high = wr_take && AVS_ADDRESS == OFS_EVNT && AVS_BYTEENABLE[0] && AVS_WRITEDATA[EV_HIGH] && s.meas;

      // Flags delivered with the low flag byte; only the bits actually sent are cleared
      clr    = (s.st == ST_TX) && scl_fall && s.bitcnt == BITS && s.widx == WORD_FLAG && s.part == PART_LO;
      n.air  = (s.air & ~(clr & s.snap[WORD_FLAG][FLAG_AIR])) | ev_air;
      n.high = (s.high & ~(clr & s.snap[WORD_FLAG][FLAG_HIGH])) | ev_high;

      // Shared timer: warm-up, stop settling and reset settling never overlap; each new load replaces the running count
      if (s.tmr != '0) begin
         n.tmr = s.tmr - 1'b1;
      end else if (s.busy) begin
         n.busy = 1'b0;
      end else if (s.meas && !s.valid) begin
         n.valid = 1'b1;
      end

      // Serial engine
      if (stop_c) begin
         n.st       = ST_IDLE;
         n.sda_oe_n = 1'b1;
         n.second   = 1'b0;
      end else if (start_c) begin
         n.st       = ST_ADDR;
         n.bitcnt   = '0;
         n.sda_oe_n = 1'b1;
         n.second   = 1'b0;
      end else begin
         unique case (s.st)
            ST_IDLE, ST_IGN: begin
               n.sda_oe_n = 1'b1;
            end
            ST_ADDR, ST_RX: begin
               if (scl_rise) begin
                  n.sr     = {s.sr[6:0], sda_in};
                  n.bitcnt = s.bitcnt + 1'b1;
               end else if (scl_fall && s.bitcnt == BITS) begin
                  n.bitcnt = '0;
                  n.st     = ST_ACK;
                  if (s.st == ST_ADDR) begin
                     n.rd = s.sr[0];
                     n.gc = 1'b0;
                     if (s.sr[7:1] == DEV_ADDR && !s.busy) begin
                        ack = s.sr[0] ? s.valid : 1'b1;
                     end else if (s.sr[7:1] == GC_ADDR && !s.sr[0] && !s.busy) begin
                        ack  = 1'b1;
                        n.gc = 1'b1;
                     end
                     if (ack && s.sr[0]) begin
                        n.snap = {flags_word, s.temp, s.flow};
                        n.part = PART_HI;
                        n.widx = '0;
                     end
                  end else if (s.gc) begin
                     ack = (s.sr == GC_RESET);
                     if (ack) begin
                        n.meas   = 1'b0;
                        n.valid  = 1'b0;
                        n.ipa    = 1'b0;
                        n.air    = 1'b0;
                        n.high   = 1'b0;
                        n.smooth = 1'b0;
                        n.busy   = 1'b1;
                        n.tmr    = TMR_W'(RESET_CYCLES - 1);
                     end
                  end else if (!s.second) begin
                     ack      = 1'b1;
                     n.cmd_hi = s.sr;
                     n.second = 1'b1;
                  end else begin
                     n.second = 1'b0;
                     if (cmd == CMD_STOP) begin
                        ack      = 1'b1;
                        n.meas   = 1'b0;
                        n.valid  = 1'b0;
                        n.smooth = 1'b0;
                        n.busy   = 1'b1;
                        n.tmr    = TMR_W'(STOP_CYCLES - 1);
                     end else if (!s.meas && (cmd == CMD_WATER || cmd == CMD_IPA)) begin
                        ack     = 1'b1;
                        n.meas  = 1'b1;
                        n.valid = 1'b0;
                        n.ipa   = (cmd == CMD_IPA);
                        n.tmr   = TMR_W'(WARM_CYCLES - 1);
                     end
                     if (ack) begin
                        n.last_cmd = cmd;
                     end
                  end
                  n.ackd     = ack;
                  n.sda_oe_n = ~ack;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  if (!s.ackd) begin
                     n.sda_oe_n = 1'b1;
                     n.st       = ST_IGN;
                  end else if (s.rd) begin
                     n.sr       = cur_byte;
                     n.sda_oe_n = cur_byte[7];
                     n.bitcnt   = 4'h1;
                     n.st       = ST_TX;
                  end else begin
                     n.sda_oe_n = 1'b1;
                     n.st       = ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (s.bitcnt == BITS) begin
                     n.sda_oe_n = 1'b1;
                     n.st       = ST_MACK;
                  end else begin
                     n.sr       = {s.sr[6:0], 1'b1};
                     n.sda_oe_n = s.sr[6];
                     n.bitcnt   = s.bitcnt + 1'b1;
                  end
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  if (sda_in) begin
                     n.st = ST_IGN;
                  end else begin
                     if (s.part == PART_CRC) begin
                        nx_part = PART_HI;
                        nx_widx = (s.widx == WORD_END) ? WORD_END : s.widx + 1'b1;
                     end else begin
                        nx_part = s.part + 1'b1;
                     end
                     n.part = nx_part;
                     n.widx = nx_widx;
                  end
               end else if (scl_fall) begin
                  n.sr       = cur_byte;
                  n.sda_oe_n = cur_byte[7];
                  n.bitcnt   = 4'h1;
                  n.st       = ST_TX;
               end
            end
            default: begin
               n.st       = ST_IDLE;
               n.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         s             <= '0;
         s.scl_sy      <= '1;
         s.sda_sy      <= '1;
         s.sr          <= '1;
         s.st          <= ST_IDLE;
         s.sda_oe_n    <= 1'b1;
         s.waitrequest <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign SDA_O           = s.sda_o;
   assign SDA_OE_N        = s.sda_oe_n;
   assign AVS_READDATA    = s.rdata;
   assign AVS_WAITREQUEST = s.waitrequest;

   AST_ADDR_MATCH: assert property (@(posedge CLK) disable iff (!RST_N)
      ($past(s.st) == ST_ADDR && s.st == ST_ACK && s.ackd)
      |-> ($past(s.sr[7:1]) == DEV_ADDR || ($past(s.sr[7:1]) == GC_ADDR && !$past(s.sr[0]))))
      else $error("Header acknowledged at a foreign address");
   AST_NO_DATA_NACK: assert property (@(posedge CLK) disable iff (!RST_N)
      ($past(s.st) == ST_ADDR && s.st == ST_ACK && s.rd && !$past(s.valid)) |-> s.sda_oe_n)
      else $error("Read header acknowledged without results");
   AST_CRC_CHECK: assert property (@(posedge CLK) disable iff (!RST_N)
      (cif.data == 16'hbeef) |-> (cif.crc == 8'h92))
      else $error("Checksum of known word is wrong");
   AST_WARM: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(s.valid) |-> ($past(s.meas) && $past(s.tmr) == '0 && !$past(s.busy)))
      else $error("Results valid before warm-up ended");
   AST_START_LOAD: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(s.meas) |-> (s.tmr == TMR_W'(WARM_CYCLES - 1) && !s.valid
         && s.ipa == (s.last_cmd == CMD_IPA)))
      else $error("Start command did not arm warm-up");
   AST_ONLY_STOP: assert property (@(posedge CLK) disable iff (!RST_N)
      $fell(s.meas) |-> (s.busy && (s.last_cmd == CMD_STOP || $past(s.gc))))
      else $error("Measurement ended without stop or reset");
   AST_DEAF: assert property (@(posedge CLK) disable iff (!RST_N)
      ($past(s.busy) && $past(s.st) == ST_ADDR && s.st == ST_ACK) |-> (!s.ackd ##1 s.sda_oe_n))
      else $error("Header acknowledged while settling");
   AST_STOP_RELEASE: assert property (@(posedge CLK) disable iff (!RST_N)
      stop_c |=> (s.sda_oe_n && s.st == ST_IDLE))
      else $error("Data line held after stop");
   // A soft reset clears the flag as well
   AST_STICKY: assert property (@(posedge CLK) disable iff (!RST_N)
      (s.air && !clr) |=> (s.air || ($past(s.gc) && s.busy)))
      else $error("Air flag dropped before readout");
   AST_RSVD: assert property (@(posedge CLK) disable iff (!RST_N)
      (s.st == ST_TX && s.widx == WORD_FLAG && s.part == PART_HI) |-> (s.snap[WORD_FLAG][15:6] == 10'h000
         && s.snap[WORD_FLAG][4:2] == 3'h0))
      else $error("Reserved flag bits not zero");
endmodule : flw_sensor_port
`default_nettype wire

// ### dv/flw_mst.sv
// Purpose: Two-wire bus master model on SCL and an open-drain SDA
// Assumes: SCL period of 125 ns, free running against the core clock
// Notes:   SCL stands high between frames; a released SDA reads high
`default_nettype none
module flw_mst (
   // Clock
   input  wire logic clk,
   // Bus lines
   output var  logic scl,
   output var  logic sda_o,
   input  wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl   = 1'b1;
      sda_o = 1'b1;
   end
   // Sixteen units make one bus clock period, so SCL never locks to the core clock
   task automatic q(input int n);
      #(7.8125 * n);
   endtask : q
   // Data moves only in mid low phase, so START and STOP stay unambiguous
   task automatic bit_x(input logic b, output logic r);
      q(4);
      sda_o <= b;
      q(4);
      scl <= 1'b1;
      q(4);
      r = sda_i;
      q(4);
      scl <= 1'b0;
   endtask : bit_x
   task automatic start();
      q(4);
      sda_o <= 1'b0;
      q(8);
      scl <= 1'b0;
   endtask : start
   task automatic stop();
      q(4);
      sda_o <= 1'b0;
      q(4);
      scl <= 1'b1;
      q(8);
      sda_o <= 1'b1;
      q(8);
      // Frames end on a core clock edge so register requests start right after one
      @(posedge clk);
   endtask : stop
   // Byte out; returns the acknowledge bit, 0 means ACK
   task automatic wr(input logic [7:0] d, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, a);
   endtask : wr
   // Byte in; nack high ends the read early
   task automatic rd(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
      bit_x(nack, r);
   endtask : rd
endmodule : flw_mst
`default_nettype wire

// ### dv/flw_sensor_port_tb_top.sv
// Purpose: Self-checking bench of the flow sensor command port
// Assumes: Short warm-up, stop and reset counts; 8 ns core clock
// Notes:   Expected bytes come from a queue model; checksum recomputed here
`default_nettype none
module flw_sensor_port_tb_top
   import flw_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WARM = 100;
   // Deaf window longer than one header, so a refusal can be probed
   localparam int DEAF = 400;
   logic        CLK, RST_N, scl, m_sda, sda_o, sda_oe_n, rd, wr, wait_rq;
   logic [3:0]  addr, be;
   logic [31:0] wdata, rdata, q;
   logic [15:0] flow, temp, flags;
   logic [7:0]  exp_q[$];
   int          num_errors, num_checks, cyc;
   wire         sda = m_sda & (sda_oe_n | sda_o);
   flw_sensor_port #(.WARM_CYCLES(WARM), .STOP_CYCLES(DEAF), .RESET_CYCLES(DEAF)) flw_sensor_port_i (
      .CLK(CLK), .RST_N(RST_N), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N(sda_oe_n),
      .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_rq));
   flw_mst flw_mst_i (.clk(CLK), .scl(scl), .sda_o(m_sda), .sda_i(sda));
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end
   always @(posedge CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         num_errors++;
         $display("CHECK FAILED at %0t: timeout", $time);
         summarize();
      end
   end
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : summarize
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: reg %h exp %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_bus(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: bus %h exp %h", $time, got, exp);
      end
   endtask : chk_bus
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      addr  <= a;
      wdata <= d;
      be    <= 4'hf;
      rd    <= ~w;
      wr    <= w;
      do @(posedge CLK); while (wait_rq !== 1'b0);
      r = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge CLK);
   endtask : av
   task automatic creg(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] r;
      av(1'b0, a, 32'h0, r);
      chk_reg(r & m, e);
   endtask : creg
   function automatic logic [7:0] crc(input logic [15:0] w);
      logic [7:0] c;
      c = 8'hff;
      for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction : crc
   task automatic send(input logic [6:0] t, input logic [15:0] c, input logic [2:0] e);
      logic a;
      flw_mst_i.start();
      flw_mst_i.wr({t, 1'b0}, a);
      chk_bus({7'h0, a}, {7'h0, e[2]});
      for (int i = 1; i >= 0 && a === 1'b0; i--) begin
         flw_mst_i.wr(c[8*i +: 8], a);
         chk_bus({7'h0, a}, {7'h0, e[i]});
      end
      flw_mst_i.stop();
   endtask : send
   task automatic rdseq(input int n, input logic e);
      logic       a;
      logic [7:0] b;
      exp_q = {flow[15:8], flow[7:0], crc(flow), temp[15:8], temp[7:0], crc(temp),
               flags[15:8], flags[7:0], crc(flags)};
      flw_mst_i.start();
      flw_mst_i.wr({DEV_ADDR, 1'b1}, a);
      chk_bus({7'h0, a}, {7'h0, e});
      for (int i = 0; i < n && a === 1'b0; i++) begin
         flw_mst_i.rd(i == n - 1, b);
         chk_bus(b, (i < 9) ? exp_q[i] : 8'hff);
      end
      flw_mst_i.stop();
      if (n > 7 && a === 1'b0) flags[1:0] = 2'b00;
   endtask : rdseq
   initial begin
      logic a, b;
      RST_N = 1'b0;
      {rd, wr, addr, wdata, be} = '0;
      {flow, temp, flags} = '0;
      void'($urandom(32'h435a86bc));
      repeat (12) @(posedge CLK);
      RST_N <= 1'b1;
      repeat (5) @(posedge CLK);
      chk_bus(crc(16'hbeef), 8'h92);
      creg(OFS_CTRL, 32'h0f, 32'h0);
      creg(4'h2, 32'hffffffff, 32'h0);
      send(7'h09, CMD_WATER, 3'b100);
      rdseq(1, 1'b1);
      send(DEV_ADDR, 16'h1234, 3'b001);
      send(DEV_ADDR, CMD_WATER, 3'b000);
      creg(OFS_CTRL, 32'h07, 32'h1);
      repeat (WARM) @(posedge CLK);
      creg(OFS_CTRL, 32'h07, 32'h3);
      creg(OFS_CMD, 32'hffff, {16'h0, CMD_WATER});
      av(1'b1, OFS_CTRL, 32'h10, q);
      flags[5] = 1'b1;
      // Rounds: air then full read, high flow then short read, both then overrun
      for (int r = 0; r < 3; r++) begin
         // Known checksum word in the first round exercises the checksum self-check
         flow = (r == 0) ? 16'hbeef : 16'($urandom);
         temp = 16'($urandom);
         av(1'b1, OFS_SMPL, {temp, flow}, q);
         av(1'b1, OFS_EVNT, 32'(r + 1), q);
         flags[1:0] = flags[1:0] | 2'(r + 1);
         creg(OFS_EVNT, 32'hffff, {16'h0, flags});
         rdseq((r == 1) ? 3 : 9 + r / 2, 1'b0);
      end
      send(DEV_ADDR, CMD_IPA, 3'b001);
      creg(OFS_CMD, 32'hffff, {16'h0, CMD_WATER});
      send(DEV_ADDR, CMD_STOP, 3'b000);
      creg(OFS_CTRL, 32'h09, 32'h8);
      send(DEV_ADDR, CMD_WATER, 3'b100);
      repeat (DEAF) @(posedge CLK);
      send(DEV_ADDR, CMD_IPA, 3'b000);
      creg(OFS_CTRL, 32'h0d, 32'h5);
      flw_mst_i.start();
      flw_mst_i.wr({GC_ADDR, 1'b0}, a);
      flw_mst_i.wr(8'h07, b);
      flw_mst_i.stop();
      chk_bus({6'h0, a, b}, 8'h01);
      creg(OFS_CTRL, 32'h09, 32'h1);
      flw_mst_i.start();
      flw_mst_i.wr({GC_ADDR, 1'b0}, a);
      flw_mst_i.wr(GC_RESET, b);
      flw_mst_i.stop();
      chk_bus({6'h0, a, b}, 8'h00);
      creg(OFS_CTRL, 32'h09, 32'h8);
      send(DEV_ADDR, CMD_WATER, 3'b100);
      repeat (DEAF) @(posedge CLK);
      send(DEV_ADDR, CMD_WATER, 3'b000);
      creg(OFS_CTRL, 32'h01, 32'h1);
      summarize();
   end
endmodule : flw_sensor_port_tb_top
`default_nettype wire
